/* pkg/gpio_params.svh */
// register indices, field positions, reset values and bus codes for the port block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
`define IDX_CONV_LATCH    4'h1
`define IDX_PLAIN_LATCH   4'h2
`define IDX_SHARED_LATCH  4'h3
`define IDX_CONV_DIR      4'h4
`define IDX_PLAIN_DIR     4'h5
`define IDX_SHARED_DIR    4'h6
`define IDX_PLAIN_PULLUP  4'h7
`define IDX_PERIPH_CTRL   4'h8
`define CTRL_SERIAL_EN    0
`define CTRL_MASTER_SEL   1
`define CTRL_ELS_LSB      2
`define CTRL_W            10
`define DIR_RESET         8'h00
`define PULLUP_RESET      8'h00
`define CTRL_RESET        10'h000
`define HTRANS_NONSEQ     2'h2
`define HSIZE_WORD        3'h2
`define HRESP_OKAY        1'h0
`endif

/* pkg/gpio_pkg.sv */
// types shared by the port block
package gpio_pkg;
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] oe;
  } pin_drive_s;

  typedef struct packed {
    logic [7:0] els;
    logic       master_sel;
    logic       serial_en;
  } periph_ctrl_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RESP = 3'b100
  } bus_state_e;
endpackage : gpio_pkg

/* hw/gpio_ports_b_c_d.sv */
// three-port gpio block with ahb-lite register slave
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/10ps
`include "gpio_params.svh"
module gpio_ports_b_c_d
  import gpio_pkg::*;
#(
  parameter int PLAIN_W = 7
) (
  input  wire logic               core_clk,
  input  wire logic               reset_n,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic [31:0]             hrdata,
  output logic                    hresp,
  input  wire logic [7:0]         conv_pin_in,
  output pin_drive_s              conv_pin_drive,
  input  wire logic [PLAIN_W-1:0] plain_pin_in,
  output logic [PLAIN_W-1:0]      plain_pin_out,
  output logic [PLAIN_W-1:0]      plain_pin_oe,
  output logic [PLAIN_W-1:0]      plain_pin_pullup,
  input  wire logic [7:0]         shared_pin_in,
  output pin_drive_s              shared_pin_drive,
  output logic [7:0]              shared_pin_level,
  input  pin_drive_s              periph_drive,
  output periph_ctrl_s            periph_ctrl
);

  logic [7:0]         conv_meta;
  logic [7:0]         conv_sync;
  logic [PLAIN_W-1:0] plain_meta;
  logic [PLAIN_W-1:0] plain_sync;
  logic [7:0]         shared_meta;
  logic [7:0]         shared_sync;
  logic [7:0]         conv_port_latch;
  logic [7:0]         conv_port_direction;
  logic [PLAIN_W-1:0] plain_port_latch;
  logic [PLAIN_W-1:0] plain_port_direction;
  logic [PLAIN_W-1:0] plain_port_pullup_enable;
  logic [7:0]         shared_port_latch;
  logic [7:0]         shared_port_direction;
  periph_ctrl_s       ctrl;
  logic [7:0]         owned;
  bus_state_e         state;
  logic [3:0]         reg_idx;
  logic               addr_ok;
  logic               is_write;
  logic               accept;
  logic               wr_en;
  logic [31:0]        next_rdata;

  function automatic logic [7:0] port_read(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] pin);
    port_read = (dir & latch) | (~dir & pin);
  endfunction : port_read

  // pin synchronisers
  always_ff @(posedge core_clk) begin
    conv_meta   <= conv_pin_in;
    conv_sync   <= conv_meta;
    plain_meta  <= plain_pin_in;
    plain_sync  <= plain_meta;
    shared_meta <= shared_pin_in;
    shared_sync <= shared_meta;
  end

  assign shared_pin_level = shared_sync;

  // ahb-lite slave: one wait state per transfer
  assign accept = hsel && hready && htrans == `HTRANS_NONSEQ;
  assign wr_en  = state == ST_WAIT && is_write && addr_ok;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      hreadyout <= 1'b1;
      hresp     <= `HRESP_OKAY;
      reg_idx   <= 4'h0;
      addr_ok   <= 1'b0;
      is_write  <= 1'b0;
    end else begin
      case (state)
        ST_IDLE, ST_RESP: begin
          if (accept) begin
            state     <= ST_WAIT;
            hreadyout <= 1'b0;
            reg_idx   <= haddr[5:2];
            addr_ok   <= haddr[31:6] == 26'h0 && haddr[1:0] == 2'h0 && hsize == `HSIZE_WORD;
            is_write  <= hwrite;
          end else begin
            state     <= ST_IDLE;
            hreadyout <= 1'b1;
          end
        end
        ST_WAIT: begin
          state     <= ST_RESP;
          hreadyout <= 1'b1;
        end
        default: begin
          state     <= ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // read mux, direction bit selects latch or pin even on owned pins
  always_comb begin
    next_rdata = 32'h0;
    if (addr_ok) begin
      case (reg_idx)
        `IDX_CONV_LATCH:   next_rdata[7:0] = port_read(conv_port_direction, conv_port_latch, conv_sync);
        `IDX_PLAIN_LATCH:  next_rdata[PLAIN_W-1:0] = PLAIN_W'(port_read(8'(plain_port_direction),
                                                     8'(plain_port_latch), 8'(plain_sync)));
        `IDX_SHARED_LATCH: next_rdata[7:0] = port_read(shared_port_direction, shared_port_latch,
                                                       shared_sync);
        `IDX_CONV_DIR:     next_rdata[7:0] = conv_port_direction;
        `IDX_PLAIN_DIR:    next_rdata[PLAIN_W-1:0] = plain_port_direction;
        `IDX_SHARED_DIR:   next_rdata[7:0] = shared_port_direction;
        `IDX_PLAIN_PULLUP: next_rdata[PLAIN_W-1:0] = plain_port_pullup_enable;
        `IDX_PERIPH_CTRL:  next_rdata[`CTRL_W-1:0] = ctrl;
        default:           next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      hrdata <= 32'h0;
    end else if (state == ST_WAIT && !is_write) begin
      hrdata <= next_rdata;
    end
  end

  // data latches: no reset, written whatever the direction
  always_ff @(posedge core_clk) begin
    if (wr_en && reg_idx == `IDX_CONV_LATCH) begin
      conv_port_latch <= hwdata[7:0];
    end
    if (wr_en && reg_idx == `IDX_PLAIN_LATCH) begin
      plain_port_latch <= hwdata[PLAIN_W-1:0];
    end
    if (wr_en && reg_idx == `IDX_SHARED_LATCH) begin
      shared_port_latch <= hwdata[7:0];
    end
  end

  // direction, pullup and peripheral control registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      conv_port_direction      <= `DIR_RESET;
      plain_port_direction     <= PLAIN_W'(`DIR_RESET);
      shared_port_direction    <= `DIR_RESET;
      plain_port_pullup_enable <= PLAIN_W'(`PULLUP_RESET);
      ctrl                     <= `CTRL_RESET;
    end else if (wr_en) begin
      case (reg_idx)
        `IDX_CONV_DIR:     conv_port_direction      <= hwdata[7:0];
        `IDX_PLAIN_DIR:    plain_port_direction     <= hwdata[PLAIN_W-1:0];
        `IDX_SHARED_DIR:   shared_port_direction    <= hwdata[7:0];
        `IDX_PLAIN_PULLUP: plain_port_pullup_enable <= hwdata[PLAIN_W-1:0];
        `IDX_PERIPH_CTRL:  ctrl                     <= hwdata[`CTRL_W-1:0];
        default:           ctrl                     <= ctrl;
      endcase
    end
  end

  assign periph_ctrl = ctrl;

  // pin ownership of the shared port
  assign owned[0] = ctrl.serial_en && !ctrl.master_sel;
  assign owned[1] = ctrl.serial_en;
  assign owned[2] = ctrl.serial_en;
  assign owned[3] = ctrl.serial_en;
  genvar t;
  generate
    for (t = 0; t < 4; t++) begin : g_timer_pin
      assign owned[4+t] = ctrl.els[2*t+1 -: 2] != 2'h0;
    end
  endgenerate

  // pin drivers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      conv_pin_drive <= '0;
    end else begin
      conv_pin_drive.oe    <= conv_port_direction;
      conv_pin_drive.value <= conv_port_latch & conv_port_direction;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      plain_pin_out    <= PLAIN_W'(0);
      plain_pin_oe     <= PLAIN_W'(0);
      plain_pin_pullup <= PLAIN_W'(0);
    end else begin
      plain_pin_out    <= plain_port_latch & plain_port_direction;
      plain_pin_oe     <= plain_port_direction;
      plain_pin_pullup <= plain_port_pullup_enable & ~plain_port_direction;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      shared_pin_drive <= '0;
    end else begin
      shared_pin_drive.oe    <= (owned & periph_drive.oe) | (~owned & shared_port_direction);
      shared_pin_drive.value <= (owned & periph_drive.value)
                              | (~owned & shared_port_direction & shared_port_latch);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_read_wait(logic [3:0] idx);
    state == ST_WAIT && !is_write && addr_ok && reg_idx == idx;
  endsequence

  sequence s_take(logic [3:0] idx, logic wr);
    accept && state != ST_WAIT && hwrite == wr && hsize == `HSIZE_WORD && haddr == {26'h0, idx, 2'h0};
  endsequence

  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_reset_dirs: assert property ($past(reset_n) == 1'b0 |-> conv_port_direction == 8'h00
      && shared_port_direction == 8'h00 && plain_port_direction == PLAIN_W'(0))
    else $error("direction bits not cleared by reset");
  a_conv_oe: assert property (##1 conv_pin_drive.oe == $past(conv_port_direction))
    else $error("converter output enable does not follow direction");
  a_conv_read: assert property (s_read_wait(`IDX_CONV_LATCH) |=> hrdata[7:0] ==
      (($past(conv_port_direction) & $past(conv_port_latch)) | (~$past(conv_port_direction) & $past(conv_sync))))
    else $error("converter port read mux wrong");
  a_latch_write: assert property (wr_en && reg_idx == `IDX_SHARED_LATCH |=>
      shared_port_latch == $past(hwdata[7:0]))
    else $error("shared latch not written");
  a_plain_read: assert property (s_read_wait(`IDX_PLAIN_LATCH) |=> hrdata[PLAIN_W-1:0] ==
      (($past(plain_port_direction) & $past(plain_port_latch)) | (~$past(plain_port_direction) & $past(plain_sync))))
    else $error("plain port read mux wrong");
  a_pullup_gate: assert property (##1 (plain_pin_pullup & $past(plain_port_direction)) == PLAIN_W'(0)
      && plain_pin_pullup == ($past(plain_port_pullup_enable) & ~$past(plain_port_direction)))
    else $error("pullup active on output or wrongly gated");
  a_ss_release: assert property (!ctrl.serial_en || ctrl.master_sel |=>
      shared_pin_drive.oe[0] == $past(shared_port_direction[0]))
    else $error("slave select not released to port");
  a_serial_own: assert property (ctrl.serial_en |=> shared_pin_drive.oe[3:1] == $past(periph_drive.oe[3:1]))
    else $error("serial pins not driven by peripheral");
  a_serial_free: assert property (!ctrl.serial_en |=> shared_pin_drive.oe[3:1] ==
      $past(shared_port_direction[3:1]))
    else $error("serial pins not returned to port");
  a_timer_own: assert property (ctrl.els[1:0] == 2'h0 |=> shared_pin_drive.oe[4] ==
      $past(shared_port_direction[4]))
    else $error("timer pin not under port control");
  a_shared_read: assert property (s_read_wait(`IDX_SHARED_LATCH) |=> hrdata[7:0] ==
      (($past(shared_port_direction) & $past(shared_port_latch))
      | (~$past(shared_port_direction) & $past(shared_sync))))
    else $error("shared port read mux wrong");
  a_latch_hold: assert property (!wr_en |=> $stable(plain_port_latch))
    else $error("plain latch changed without write");

  a_conv_write: assert property (s_take(`IDX_CONV_LATCH, 1'b1) |=> s_one_wait ##0
      conv_port_latch == $past(hwdata[7:0]))
    else $error("converter latch write late or wrong");
  a_shared_fetch: assert property (s_take(`IDX_SHARED_LATCH, 1'b0) |=> s_one_wait ##0 hrdata[7:0] ==
      (($past(shared_port_direction) & $past(shared_port_latch))
      | (~$past(shared_port_direction) & $past(shared_sync))))
    else $error("shared port read data late or wrong");

  a_sync_delay: assert property (##2 conv_sync == $past(conv_pin_in, 2))
    else $error("converter pin level not synchronised in two stages");
  a_plain_sync: assert property (##2 plain_sync == $past(plain_pin_in, 2))
    else $error("plain pin level not synchronised in two stages");
  a_level_out: assert property (##2 shared_pin_level == $past(shared_pin_in, 2))
    else $error("shared pin level not synchronised in two stages");
  a_conv_value: assert property (##1 conv_pin_drive.value ==
      ($past(conv_port_latch) & $past(conv_port_direction)))
    else $error("converter pin value does not follow latch");
  a_plain_drive: assert property (##1 plain_pin_oe == $past(plain_port_direction)
      && plain_pin_out == ($past(plain_port_latch) & $past(plain_port_direction)))
    else $error("plain pin drive does not follow latch and direction");

  a_conv_dir_write: assert property (wr_en && reg_idx == `IDX_CONV_DIR |=>
      conv_port_direction == $past(hwdata[7:0]))
    else $error("converter direction not written");
  a_plain_dir_write: assert property (wr_en && reg_idx == `IDX_PLAIN_DIR |=>
      plain_port_direction == $past(hwdata[PLAIN_W-1:0]))
    else $error("plain direction not written");
  a_shared_dir_write: assert property (wr_en && reg_idx == `IDX_SHARED_DIR |=>
      shared_port_direction == $past(hwdata[7:0]))
    else $error("shared direction not written");
  a_pullup_write: assert property (wr_en && reg_idx == `IDX_PLAIN_PULLUP |=>
      plain_port_pullup_enable == $past(hwdata[PLAIN_W-1:0]))
    else $error("pullup enable not written");
  a_ctrl_write: assert property (wr_en && reg_idx == `IDX_PERIPH_CTRL |=>
      ctrl == $past(hwdata[`CTRL_W-1:0]))
    else $error("peripheral control not written");
  a_plain_write: assert property (wr_en && reg_idx == `IDX_PLAIN_LATCH |=>
      plain_port_latch == $past(hwdata[PLAIN_W-1:0]))
    else $error("plain latch not written");

  a_ss_own: assert property (ctrl.serial_en && !ctrl.master_sel |=>
      shared_pin_drive.oe[0] == $past(periph_drive.oe[0]))
    else $error("slave select not handed to peripheral");
  a_serial_value: assert property (ctrl.serial_en |=>
      shared_pin_drive.value[3:1] == $past(periph_drive.value[3:1]))
    else $error("serial pin values not taken from peripheral");
  a_serial_latch: assert property (!ctrl.serial_en |=> shared_pin_drive.value[3:1] ==
      ($past(shared_port_latch[3:1]) & $past(shared_port_direction[3:1])))
    else $error("serial pin values not taken from latch");

  generate
    for (genvar p = 0; p < 4; p++) begin : g_timer_check
      a_timer_free: assert property (@(posedge core_clk) disable iff (!reset_n)
          ctrl.els[2*p+1 -: 2] == 2'h0 |=> shared_pin_drive.oe[4+p] == $past(shared_port_direction[4+p]))
        else $error("timer pin left out of port control");
      a_timer_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
          ctrl.els[2*p+1 -: 2] != 2'h0 |=> shared_pin_drive.oe[4+p] == $past(periph_drive.oe[4+p])
          && shared_pin_drive.value[4+p] == $past(periph_drive.value[4+p]))
        else $error("timer pin not driven by its timer");
    end
  endgenerate

endmodule : gpio_ports_b_c_d

/* tb/gpio_pin_board.sv */
// board-side model of the three port pin groups
`timescale 1ns/10ps
module gpio_pin_board
  import gpio_pkg::*;
(
  input  wire pin_drive_s  conv_drive,
  input  wire logic [7:0]  conv_ext,
  input  wire logic [6:0]  plain_out,
  input  wire logic [6:0]  plain_oe,
  input  wire logic [6:0]  plain_pullup,
  input  wire logic [6:0]  plain_ext,
  input  wire pin_drive_s  shared_drive,
  input  wire logic [7:0]  shared_ext,
  output logic [7:0]       conv_level,
  output logic [6:0]       plain_level,
  output logic [7:0]       shared_level
);
  // driven pins show the driven value, floating pins the board level, plain port floating pins high where the pullup is on
  assign conv_level = (conv_drive.oe & conv_drive.value) | (~conv_drive.oe & conv_ext);
  assign plain_level = (plain_oe & plain_out) | (~plain_oe & (plain_pullup | plain_ext));
  assign shared_level = (shared_drive.oe & shared_drive.value) | (~shared_drive.oe & shared_ext);
endmodule : gpio_pin_board

/* tb/test_gpio_ports_b_c_d.sv */
// self-checking bench for the three-port gpio block
`timescale 1ns/10ps
`include "gpio_params.svh"
module test_gpio_ports_b_c_d;
  import gpio_pkg::*;
  logic         core_clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0]  haddr, hwdata, hrdata;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [7:0]   conv_pin_in, shared_pin_in, shared_pin_level, conv_ext, shared_ext;
  logic [6:0]   plain_pin_in, plain_pin_out, plain_pin_oe, plain_pin_pullup, plain_ext;
  pin_drive_s   conv_pin_drive, shared_pin_drive, periph_drive;
  periph_ctrl_s periph_ctrl;
  int           error_cnt, cmp_count, cycles;

  gpio_ports_b_c_d #(.PLAIN_W(7)) i_dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .conv_pin_in(conv_pin_in), .conv_pin_drive(conv_pin_drive),
    .plain_pin_in(plain_pin_in), .plain_pin_out(plain_pin_out), .plain_pin_oe(plain_pin_oe),
    .plain_pin_pullup(plain_pin_pullup), .shared_pin_in(shared_pin_in), .shared_pin_drive(shared_pin_drive),
    .shared_pin_level(shared_pin_level), .periph_drive(periph_drive), .periph_ctrl(periph_ctrl));

  gpio_pin_board i_board (.conv_drive(conv_pin_drive), .conv_ext(conv_ext), .plain_out(plain_pin_out),
    .plain_oe(plain_pin_oe), .plain_pullup(plain_pin_pullup), .plain_ext(plain_ext),
    .shared_drive(shared_pin_drive), .shared_ext(shared_ext), .conv_level(conv_pin_in),
    .plain_level(plain_pin_in), .shared_level(shared_pin_in));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task give_verdict;
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] addr(input logic [3:0] idx);
    return {26'h0, idx, 2'b00};
  endfunction : addr

  task bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= `HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= `HSIZE_WORD;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", `HRESP_OKAY, hresp);
  endtask : bus

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr

  task rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk($sformatf("read %h", a), exp, r);
  endtask : rd_chk

  task settle;
    repeat (4) @(posedge core_clk);
  endtask : settle

  task t_reset_vals;
    for (int i = 4; i < 9; i++) rd_chk(addr(4'(i)), 32'h0);
    chk("conv oe", 8'h00, conv_pin_drive.oe);
    chk("plain oe", 7'h00, plain_pin_oe);
    chk("plain pullup", 7'h00, plain_pin_pullup);
    chk("shared oe", 8'h00, shared_pin_drive.oe);
  endtask : t_reset_vals

  task t_conv;
    wr(addr(`IDX_CONV_LATCH), 32'ha5);
    settle;
    rd_chk(addr(`IDX_CONV_LATCH), 32'h5a);
    wr(addr(`IDX_CONV_DIR), 32'h0f);
    settle;
    chk("conv oe", 8'h0f, conv_pin_drive.oe);
    chk("conv value", 8'h05, conv_pin_drive.value);
    rd_chk(addr(`IDX_CONV_LATCH), 32'h55);
  endtask : t_conv

  task t_plain;
    wr(addr(`IDX_PLAIN_LATCH), 32'h55);
    wr(addr(`IDX_PLAIN_PULLUP), 32'h7f);
    wr(addr(`IDX_PLAIN_DIR), 32'h03);
    settle;
    chk("plain pullup", 7'h7c, plain_pin_pullup);
    chk("plain oe", 7'h03, plain_pin_oe);
    chk("plain out", 7'h01, plain_pin_out);
    rd_chk(addr(`IDX_PLAIN_LATCH), 32'h7d);
    wr(addr(`IDX_PLAIN_PULLUP), 32'h0f);
    settle;
    chk("plain pullup", 7'h0c, plain_pin_pullup);
    rd_chk(addr(`IDX_PLAIN_LATCH), 32'h0d);
    rd_chk(addr(`IDX_PLAIN_DIR), 32'h03);
  endtask : t_plain

  task t_owner(input logic [9:0] ctrl, input logic [7:0] m);
    logic [7:0] eo, ev, pin;
    eo = (periph_drive.oe & m) | (8'h5a & ~m);
    ev = (periph_drive.value & m) | (8'h3c & 8'h5a & ~m);
    pin = (eo & ev) | (~eo & shared_ext);
    wr(addr(`IDX_PERIPH_CTRL), {22'h0, ctrl});
    settle;
    chk("periph ctrl", ctrl, periph_ctrl);
    chk("shared oe", eo, shared_pin_drive.oe);
    chk("shared value", ev, shared_pin_drive.value);
    chk("shared level", pin, shared_pin_level);
    rd_chk(addr(`IDX_SHARED_LATCH), (8'h3c & 8'h5a) | (pin & 8'ha5));
  endtask : t_owner

  task t_shared;
    logic [9:0] ctl [9];
    logic [7:0] msk [9];
    ctl = '{10'h000, 10'h001, 10'h003, 10'h002, 10'h004, 10'h020, 10'h0c0, 10'h100, 10'h000};
    msk = '{8'h00, 8'h0f, 8'h0e, 8'h00, 8'h10, 8'h20, 8'h40, 8'h80, 8'h00};
    wr(addr(`IDX_SHARED_LATCH), 32'h3c);
    wr(addr(`IDX_SHARED_DIR), 32'h5a);
    for (int i = 0; i < 9; i++) t_owner(ctl[i], msk[i]);
  endtask : t_shared

  task t_retain;
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_reset_vals();
    wr(addr(`IDX_PLAIN_DIR), 32'h7f);
    wr(addr(`IDX_SHARED_DIR), 32'hff);
    settle;
    chk("plain out", 7'h55, plain_pin_out);
    rd_chk(addr(`IDX_PLAIN_LATCH), 32'h55);
    rd_chk(addr(`IDX_SHARED_LATCH), 32'h3c);
    rd_chk(addr(4'h0), 32'h0);
    wr(addr(4'h9), 32'hffffffff);
    rd_chk(addr(4'h9), 32'h0);
    rd_chk(addr(`IDX_PLAIN_DIR), 32'h7f);
  endtask : t_retain

  initial begin
    reset_n <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= `HSIZE_WORD;
    hwdata <= 32'h0;
    conv_ext <= 8'h5a;
    plain_ext <= 7'h00;
    shared_ext <= 8'h96;
    periph_drive <= '{value: 8'hc3, oe: 8'ha5};
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_reset_vals();
    t_conv();
    t_plain();
    t_shared();
    t_retain();
    give_verdict();
  end
endmodule : test_gpio_ports_b_c_d
